// [verilog/sspi_master.sv]
// sspi_master: full-duplex simplified spi master channel with register port
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module sspi_master #(
    parameter bit IS_FIRST_CHANNEL = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic peripheralClockEnable,
    // register port
    input wire logic [sspi_pkg::ADDR_W-1:0] regAddr,
    input wire logic [sspi_pkg::REG_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [sspi_pkg::REG_W-1:0] regRdData,
    // serial link
    output logic serialClockPin,
    output logic serialOutputPin,
    input wire logic serialInputPin,
    // transfer event
    output logic channelTransferInterrupt
);
    import sspi_pkg::*;

    sspi_cfg_s cfg_r;
    sspi_stat_s stat;
    sspi_state_e state_r;
    logic [3:0] clkExp_r;
    logic [DIV_W-1:0] clkDiv_r;
    logic enabled_r, soe_r, soLevel_r, ckoLevel_r;
    logic [7:0] txBuf_r, txByte_r, rxByte_r, rxData_r, rxFinal, loadByte;
    logic bufFull_r, rxUnread_r, overrun_r;
    logic [3:0] edgeCnt_r;
    logic sckInt_r, outBit_r, halfTick, sinLevel;
    logic unitClr, wrData, rdData, wrComm, wrClk, wrCtrl, wrOut, stopReq;
    logic busy, lastEdge, frameDone, start;
    logic [2:0] bitIdx, curPos, nextPos, firstPos;

    assign unitClr = !peripheralClockEnable;
    assign wrData = regWr && regAddr == OFS_DATA;
    assign rdData = regRd && regAddr == OFS_DATA;
    assign wrComm = regWr && regAddr == OFS_COMM;
    assign wrClk = regWr && regAddr == OFS_CLK;
    assign wrCtrl = regWr && regAddr == OFS_CTRL;
    assign wrOut = regWr && regAddr == OFS_OUT;
    assign stopReq = wrCtrl && regWrData[CTL_STOP];

    assign busy = state_r == ST_SHIFT;
    assign bitIdx = edgeCnt_r[3:1];
    assign lastEdge = edgeCnt_r == (cfg_r.len7 ? LAST_EDGE7 : LAST_EDGE8);
    assign frameDone = busy && halfTick && lastEdge;
    // same order on both directions
    assign curPos = bitPos(bitIdx, cfg_r.lsbFirst, cfg_r.len7);
    assign nextPos = bitPos(bitIdx + 3'h1, cfg_r.lsbFirst, cfg_r.len7);
    assign firstPos = bitPos(3'h0, cfg_r.lsbFirst, cfg_r.len7);
    // a write in the last edge's cycle goes straight into the next frame
    assign loadByte = wrData ? regWrData[7:0] : txBuf_r;
    assign start = enabled_r && !unitClr && !stopReq
        && ((wrData && !busy) || (frameDone && (bufFull_r || wrData)));

    sspi_clk_div #(
        .IS_FIRST_CHANNEL(IS_FIRST_CHANNEL)
    ) u_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(busy && !unitClr),
        .expSel(clkExp_r),
        .divSel(clkDiv_r),
        .halfTick(halfTick)
    );

    sspi_in_sync u_sin (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(serialInputPin),
        .level(sinLevel)
    );

    // configuration, may change during a frame
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg_r <= CFG_RST;
            clkExp_r <= EXP_RST;
            clkDiv_r <= DIV_RST;
        end else if (unitClr) begin
            cfg_r <= CFG_RST;
            clkExp_r <= EXP_RST;
            clkDiv_r <= DIV_RST;
        end else begin
            if (wrComm) begin
                cfg_r <= sspi_cfg_s'(regWrData[CFG_W-1:0]);
            end
            if (wrClk) begin
                clkExp_r <= regWrData[CLK_EXP_LSB +: 4];
                clkDiv_r <= regWrData[CLK_DIV_LSB +: DIV_W];
            end
        end
    end

    // channel enable
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            enabled_r <= 1'b0;
        end else if (unitClr || stopReq) begin
            enabled_r <= 1'b0;
        end else if (wrCtrl && regWrData[CTL_START]) begin
            enabled_r <= 1'b1;
        end
    end

    // output enable and stopped-state pin levels
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            soe_r <= OUT_SOE_RST;
            soLevel_r <= OUT_SO_RST;
            ckoLevel_r <= OUT_CKO_RST;
        end else if (unitClr) begin
            soe_r <= OUT_SOE_RST;
            soLevel_r <= OUT_SO_RST;
            ckoLevel_r <= OUT_CKO_RST;
        end else if (wrOut) begin
            soe_r <= regWrData[OUT_SOE];
            if (!enabled_r) begin
                soLevel_r <= regWrData[OUT_SO];
                ckoLevel_r <= regWrData[OUT_CKO];
            end
        end
    end

    // transmit buffer
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            txBuf_r <= BYTE_RST;
            bufFull_r <= 1'b0;
        end else if (unitClr || stopReq) begin
            txBuf_r <= BYTE_RST;
            bufFull_r <= 1'b0;
        end else if (start) begin
            bufFull_r <= 1'b0;
        end else if (wrData && enabled_r && busy) begin
            txBuf_r <= regWrData[7:0];
            bufFull_r <= 1'b1;
        end
    end

    // received byte including a last bit sampled on the closing edge
    always_comb begin
        rxFinal = rxByte_r;
        if (!cfg_r.dataPhase) begin
            rxFinal[curPos] = sinLevel;
        end
    end

    // receive data and overrun
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rxData_r <= BYTE_RST;
            rxUnread_r <= 1'b0;
            overrun_r <= 1'b0;
        end else if (unitClr) begin
            rxData_r <= BYTE_RST;
            rxUnread_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            if (frameDone) begin
                rxData_r <= rxFinal;
            end
            rxUnread_r <= frameDone || (rxUnread_r && !rdData);
            // set wins over clear
            overrun_r <= (frameDone && rxUnread_r && !rdData)
                || (overrun_r && !(wrCtrl && regWrData[CTL_CLROVR]));
        end
    end

    // frame engine
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            edgeCnt_r <= EDGE_RST;
            sckInt_r <= SCK_IDLE;
            outBit_r <= OUT_SO_RST;
            txByte_r <= BYTE_RST;
            rxByte_r <= BYTE_RST;
        end else if (unitClr || stopReq) begin
            state_r <= ST_IDLE;
            edgeCnt_r <= EDGE_RST;
            sckInt_r <= SCK_IDLE;
        end else if (start) begin
            state_r <= ST_SHIFT;
            edgeCnt_r <= EDGE_RST;
            sckInt_r <= SCK_IDLE;
            txByte_r <= loadByte;
            rxByte_r <= BYTE_RST;
            if (cfg_r.dataPhase) begin
                outBit_r <= loadByte[firstPos];
            end
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_r <= ST_IDLE;
                end
                ST_SHIFT: begin
                    if (halfTick) begin
                        sckInt_r <= !sckInt_r;
                        edgeCnt_r <= edgeCnt_r + 4'h1;
                        if (lastEdge) begin
                            state_r <= ST_IDLE;
                        end
                        if (!edgeCnt_r[0]) begin
                            if (cfg_r.dataPhase) begin
                                rxByte_r[curPos] <= sinLevel;
                            end else begin
                                outBit_r <= txByte_r[curPos];
                            end
                        end else if (!cfg_r.dataPhase) begin
                            rxByte_r[curPos] <= sinLevel;
                        end else if (!lastEdge) begin
                            outBit_r <= txByte_r[nextPos];
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // pins
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            serialClockPin <= OUT_CKO_RST;
            serialOutputPin <= OUT_SO_RST;
        end else begin
            serialClockPin <= enabled_r ? sckInt_r ^ cfg_r.clkInvert : ckoLevel_r;
            serialOutputPin <= (enabled_r && soe_r) ? outBit_r : soLevel_r;
        end
    end

    // transfer end in single mode, buffer empty in continuous mode
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            channelTransferInterrupt <= 1'b0;
        end else begin
            channelTransferInterrupt <= !unitClr && !stopReq
                && (cfg_r.intTiming ? start : frameDone);
        end
    end

    assign stat = '{channelEnabled: enabled_r, overrun: overrun_r, bufferFull: bufFull_r, transferActive: busy};

    // read data for one cycle only
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            regRdData <= '0;
        end else if (!regRd) begin
            regRdData <= '0;
        end else begin
            case (regAddr)
                OFS_DATA: regRdData <= {8'h00, rxData_r};
                OFS_COMM: regRdData <= REG_W'(cfg_r);
                OFS_CLK: regRdData <= {1'b0, clkDiv_r, 4'h0, clkExp_r};
                OFS_STAT: regRdData <= REG_W'(stat);
                OFS_OUT: regRdData <= {13'h0000, ckoLevel_r, soLevel_r, soe_r};
                default: regRdData <= '0;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    property p_stop;
        stopReq |=> !enabled_r && !busy && !bufFull_r;
    endproperty
    a_stop: assert property (p_stop) else $error("stop trigger left the channel running");

    property p_start;
        enabled_r && wrData && !busy && !stopReq && !unitClr |=> busy && txByte_r == $past(regWrData[7:0]);
    endproperty
    a_start: assert property (p_start) else $error("data write did not start a frame");

    property p_done;
        frameDone && !cfg_r.intTiming && !stopReq && !unitClr
            |=> channelTransferInterrupt && rxUnread_r && rxData_r == $past(rxFinal);
    endproperty
    a_done: assert property (p_done) else $error("frame end event or data missing");

    property p_empty;
        start && cfg_r.intTiming |=> channelTransferInterrupt ##1 !channelTransferInterrupt;
    endproperty
    a_empty: assert property (p_empty) else $error("buffer empty event missing");

    property p_phase1;
        start && cfg_r.dataPhase |=> outBit_r == $past(loadByte[firstPos]) && sckInt_r == SCK_IDLE;
    endproperty
    a_phase1: assert property (p_phase1) else $error("first bit not presented before clock");

    property p_phase0;
        busy && halfTick && edgeCnt_r == EDGE_RST && !cfg_r.dataPhase && !stopReq && !unitClr
            |=> outBit_r == $past(txByte_r[curPos]) && sckInt_r != SCK_IDLE;
    endproperty
    a_phase0: assert property (p_phase0) else $error("first bit not shifted on first edge");

    property p_pol;
        (enabled_r && !busy && $stable(cfg_r)) [*2] |-> serialClockPin == (SCK_IDLE ^ cfg_r.clkInvert);
    endproperty
    a_pol: assert property (p_pol) else $error("idle clock level ignores polarity");

    property p_soe;
        (!soe_r && $stable(soLevel_r)) [*2] |-> serialOutputPin == soLevel_r;
    endproperty
    a_soe: assert property (p_soe) else $error("shift logic drives output while disabled");

    property p_lvl;
        wrOut && !enabled_r && !unitClr |=> ##1 serialClockPin == $past(regWrData[OUT_CKO], 2);
    endproperty
    a_lvl: assert property (p_lvl) else $error("level write did not reach clock pin");

    property p_ovr;
        frameDone && rxUnread_r && !rdData && !unitClr |=> overrun_r;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");

    property p_ovw;
        wrData && enabled_r && busy && !start && !stopReq && !unitClr |=> bufFull_r && txBuf_r == $past(regWrData[7:0]);
    endproperty
    a_ovw: assert property (p_ovw) else $error("pending data not overwritten");

    property p_pclk;
        unitClr |=> !enabled_r && !busy && !bufFull_r && !overrun_r && cfg_r == CFG_RST;
    endproperty
    a_pclk: assert property (p_pclk) else $error("clock gating did not reset the unit");

    property p_rate;
        halfTick && !IS_FIRST_CHANNEL |=> !halfTick;
    endproperty
    a_rate: assert property (p_rate) else $error("serial clock faster than a quarter");

    c_frame: cover property (frameDone && !cfg_r.intTiming);
    c_chain: cover property (frameDone && start);
    c_ovr: cover property (frameDone && rxUnread_r);
    c_abort: cover property (busy && stopReq);
endmodule

// [verilog/sspi_pkg.sv]
// sspi_pkg: constants and types of the simplified spi master channel
package sspi_pkg;
    // register port
    localparam int ADDR_W = 5;
    localparam int REG_W = 16;
    localparam logic [ADDR_W-1:0] OFS_DATA = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_COMM = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CLK = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STAT = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_OUT = 5'h14;
    // field positions
    localparam int CFG_W = 5;
    localparam int CLK_EXP_LSB = 0;
    localparam int CLK_DIV_LSB = 8;
    localparam int CTL_START = 0;
    localparam int CTL_STOP = 1;
    localparam int CTL_CLROVR = 2;
    localparam int OUT_SOE = 0;
    localparam int OUT_SO = 1;
    localparam int OUT_CKO = 2;
    // clock generation: half period is 2**exp * (div + 1) cycles
    localparam int PRESC_W = 15;
    localparam int DIV_W = 7;
    localparam logic [3:0] EXP_RST = 4'h0;
    localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
    localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;
    // frame
    localparam logic [3:0] EDGE_RST = 4'h0;
    localparam logic [3:0] LAST_EDGE8 = 4'hF;
    localparam logic [3:0] LAST_EDGE7 = 4'hD;
    localparam logic SCK_IDLE = 1'b1;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic OUT_SOE_RST = 1'b0;
    localparam logic OUT_SO_RST = 1'b1;
    localparam logic OUT_CKO_RST = 1'b1;
    localparam logic SYNC_RST = 1'b0;

    typedef struct packed {
        logic intTiming;
        logic len7;
        logic lsbFirst;
        logic clkInvert;
        logic dataPhase;
    } sspi_cfg_s;

    typedef struct packed {
        logic channelEnabled;
        logic overrun;
        logic bufferFull;
        logic transferActive;
    } sspi_stat_s;

    localparam sspi_cfg_s CFG_RST = 5'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } sspi_state_e;

    // byte position of the idx-th bit on the wire
    function automatic logic [2:0] bitPos(input logic [2:0] idx, input logic lsbFirst, input logic len7);
        if (lsbFirst) begin
            return idx;
        end
        return len7 ? 3'h6 - idx : 3'h7 - idx;
    endfunction
endpackage

// [verilog/sspi_in_sync.sv]
// sspi_in_sync: three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module sspi_in_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // pin and filtered level
    input wire logic pinIn,
    output logic level
);
    import sspi_pkg::*;
    logic s1_r, s2_r, s3_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
            s3_r <= SYNC_RST;
            level <= SYNC_RST;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level <= s3_r;
            end
        end
    end
endmodule

// [verilog/sspi_clk_div.sv]
// sspi_clk_div: prescaler and divider giving serial half-period ticks
`timescale 1ns/1ns
module sspi_clk_div #(
    parameter bit IS_FIRST_CHANNEL = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic run,
    input wire logic [3:0] expSel,
    input wire logic [sspi_pkg::DIV_W-1:0] divSel,
    // tick every half serial period
    output logic halfTick
);
    import sspi_pkg::*;
    logic [PRESC_W-1:0] presc_r, prescLimit;
    logic [DIV_W-1:0] div_r, divLimit;
    logic prescTick;

    assign prescLimit = PRESC_W'((16'h0001 << expSel) - 16'h0001);
    assign prescTick = presc_r == prescLimit;
    // only the first channel may toggle on every cycle
    assign divLimit = (!IS_FIRST_CHANNEL && expSel == EXP_RST && divSel == DIV_RST) ? DIV_ONE : divSel;
    assign halfTick = run && prescTick && div_r == divLimit;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            presc_r <= '0;
            div_r <= DIV_RST;
        end else if (!run) begin
            presc_r <= '0;
            div_r <= DIV_RST;
        end else if (prescTick) begin
            presc_r <= '0;
            div_r <= (div_r == divLimit) ? DIV_RST : div_r + DIV_ONE;
        end else begin
            presc_r <= presc_r + PRESC_W'(1);
        end
    end
endmodule

// [tb/sspi_slave_model.sv]
// sspi_slave_model: behavioural spi slave on the far side of the link
`timescale 1ns/1ns
module sspi_slave_model (
    // serial link
    input wire logic serialClockPin,
    input wire logic serialOutputPin,
    output logic serialInputPin,
    // setup from the bench
    input wire logic clkInvert,
    input wire logic dataPhase,
    input wire logic len7,
    input wire logic [7:0] txByte,
    input wire logic load,
    output logic [7:0] rxWire
);
    int sh = 0;
    int cnt = 0;
    logic lead;
    initial serialInputPin = 1'h0;
    initial rxWire = 8'h00;
    // arm a frame; phase 1 shows its first bit before any clock
    always @(posedge load) begin
        sh = dataPhase ? 1 : 0;
        cnt = 0;
        rxWire = 8'h00;
        serialInputPin = dataPhase ? txByte[7] : ~serialInputPin;
    end
    always @(serialClockPin) begin
        lead = serialClockPin !== (1'h1 ^ clkInvert);
        if (lead != dataPhase) begin
            // past the frame the released line wanders
            serialInputPin = (sh < (len7 ? 7 : 8)) ? txByte[7 - sh] : ~serialInputPin;
            sh++;
        end else begin
            rxWire = {rxWire[6:0], serialOutputPin};
            cnt++;
            if (cnt == (len7 ? 7 : 8) && !dataPhase) begin
                serialInputPin = ~serialInputPin;
            end
        end
    end
endmodule

// [tb/tb_top.sv]
// tb_top: self-checking bench of the spi master channel against a slave model
`timescale 1ns/1ns
module tb_top;
    import sspi_pkg::*;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic peripheralClockEnable = 1'h1;
    logic [ADDR_W-1:0] regAddr = 5'h00;
    logic [REG_W-1:0] regWrData = 16'h0000;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic [REG_W-1:0] regRdData;
    logic serialClockPin;
    logic serialOutputPin;
    logic serialInputPin;
    logic channelTransferInterrupt;
    logic [7:0] sTx = 8'h00;
    logic sLoad = 1'h0;
    logic [7:0] rxWire;
    logic [4:0] cfg = 5'h00;
    logic [15:0] rnd = 16'h6045;
    logic [15:0] rdv;
    int edges = 0;
    int errors = 0;
    int num_checks = 0;
    logic qClk;
    int qEdges = 0;

    always #2 sys_clk = ~sys_clk;
    always @(serialClockPin) edges++;
    always @(qClk) qEdges++;

    sspi_master u_sspi_master (.sys_clk(sys_clk), .reset(reset), .peripheralClockEnable(peripheralClockEnable),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .serialClockPin(serialClockPin), .serialOutputPin(serialOutputPin), .serialInputPin(serialInputPin),
        .channelTransferInterrupt(channelTransferInterrupt));
    sspi_slave_model u_sspi_slave_model (.serialClockPin(serialClockPin), .serialOutputPin(serialOutputPin),
        .serialInputPin(serialInputPin), .clkInvert(cfg[1]), .dataPhase(cfg[0]), .len7(cfg[3]),
        .txByte(sTx), .load(sLoad), .rxWire(rxWire));
    // a later channel on the same stimulus, limited to a quarter rate
    sspi_master #(.IS_FIRST_CHANNEL(1'h0)) u_sspi_master_q (.sys_clk(sys_clk), .reset(reset),
        .peripheralClockEnable(peripheralClockEnable), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(), .serialClockPin(qClk), .serialOutputPin(), .serialInputPin(serialInputPin),
        .channelTransferInterrupt());

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // reorders a byte between wire order and register order
    function automatic logic [7:0] wireMap(input logic [7:0] b, input logic [4:0] c, input logic toRx);
        logic [7:0] r;
        int n;
        int p;
        r = 8'h00;
        n = c[3] ? 7 : 8;
        for (int k = 0; k < n; k++) begin
            p = c[2] ? k : n - 1 - k;
            if (toRx) begin
                r[p] = b[7 - k];
            end else begin
                r[n - 1 - k] = b[p];
            end
        end
        return r;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge sys_clk);
        regWr <= 1'h0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge sys_clk);
        regRd <= 1'h0;
        #1 rdv = regRdData;
    endtask
    task automatic waitIrq(input int lim);
        int i;
        #1;
        for (i = 0; i < lim && channelTransferInterrupt !== 1'h1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (i == lim) begin
            chk(16'h0000, 16'h0001);
        end
    endtask
    task automatic arm();
        rnd = lfsr(rnd);
        sTx = rnd[15:8];
        sLoad = 1'h1;
        #1 sLoad = 1'h0;
    endtask
    task automatic frame(input logic [7:0] t);
        int n;
        n = cfg[3] ? 7 : 8;
        arm();
        edges = 0;
        wr(OFS_DATA, {8'h00, t});
        repeat (2) @(posedge sys_clk);
        #1;
        if (cfg[0]) begin
            chk(serialOutputPin, t[cfg[2] ? 0 : n - 1]);
        end
        chk(serialClockPin, 1'h1 ^ cfg[1]);
        waitIrq(400);
        rd(OFS_DATA);
        chk(rdv, {8'h00, wireMap(sTx, cfg, 1'h1)});
        chk(rxWire, wireMap(t, cfg, 1'h0));
        chk(16'(edges), 16'(2 * n));
    endtask
    task automatic results();
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // span far beyond the expected run
    initial begin
        #80000;
        errors++;
        results();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'h0;
        #1 chk({serialClockPin, serialOutputPin}, 2'h3);
        rd(OFS_OUT);
        chk(rdv, 16'h0006);
        rd(5'h1C);
        chk(rdv, 16'h0000);
        wr(OFS_CTRL, 16'h0001);
        wr(OFS_OUT, 16'h0007);
        wr(OFS_CLK, 16'h0301);
        rd(OFS_STAT);
        chk(rdv, 16'h0008);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            cfg = {1'h0, rnd[3:2], 2'(i)};
            wr(OFS_COMM, {11'h000, cfg});
            repeat (4) @(posedge sys_clk);
            frame(rnd[15:8]);
        end
        // back to back frames, pending byte overwritten
        arm();
        wr(OFS_DATA, 16'h005A);
        rd(OFS_STAT);
        chk(rdv, 16'h0009);
        wr(OFS_DATA, 16'h00C3);
        wr(OFS_DATA, 16'h003C);
        rd(OFS_STAT);
        chk(rdv, 16'h000B);
        waitIrq(400);
        @(posedge sys_clk);
        waitIrq(400);
        chk(rxWire & (cfg[3] ? 8'h7F : 8'hFF), wireMap(8'h3C, cfg, 1'h0));
        rd(OFS_STAT);
        chk(rdv, 16'h000C);
        wr(OFS_CTRL, 16'h0004);
        rd(OFS_STAT);
        chk(rdv, 16'h0008);
        rd(OFS_DATA);
        // continuous mode: event at frame start
        wr(OFS_COMM, {11'h000, cfg | 5'h10});
        arm();
        wr(OFS_DATA, 16'h0081);
        waitIrq(3);
        rd(OFS_STAT);
        chk(rdv, 16'h0009);
        repeat (200) @(posedge sys_clk);
        rd(OFS_DATA);
        chk(rdv, {8'h00, wireMap(sTx, cfg, 1'h1)});
        // urgent stop in mid-frame
        wr(OFS_DATA, 16'h0055);
        repeat (20) @(posedge sys_clk);
        wr(OFS_CTRL, 16'h0002);
        rd(OFS_STAT);
        chk(rdv, 16'h0000);
        chk(serialClockPin, OUT_CKO_RST);
        wr(OFS_OUT, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1 chk({serialClockPin, serialOutputPin}, 2'h0);
        wr(OFS_OUT, 16'h0002);
        repeat (2) @(posedge sys_clk);
        #1 chk({serialClockPin, serialOutputPin}, 2'h1);
        wr(OFS_DATA, 16'h00FF);
        rd(OFS_STAT);
        chk(rdv, 16'h0000);
        // unit clock removal
        @(posedge sys_clk);
        peripheralClockEnable <= 1'h0;
        repeat (2) @(posedge sys_clk);
        peripheralClockEnable <= 1'h1;
        @(posedge sys_clk);
        #1 chk({serialClockPin, serialOutputPin}, 2'h3);
        rd(OFS_OUT);
        chk(rdv, 16'h0006);
        rd(OFS_COMM);
        chk(rdv, 16'h0000);
        // full re-initialisation, then fastest clock
        wr(OFS_CTRL, 16'h0001);
        wr(OFS_OUT, 16'h0007);
        wr(OFS_CLK, 16'h7F0F);
        rd(OFS_CLK);
        chk(rdv, 16'h7F0F);
        wr(OFS_CLK, 16'h0000);
        edges = 0;
        qEdges = 0;
        wr(OFS_DATA, 16'h00A5);
        repeat (18) @(posedge sys_clk);
        #1 chk(16'(edges), 16'h0010);
        chk(16'(qEdges), 16'h0008);
        results();
    end
endmodule
